// *** hdl/dsr_defs.svh ***
`ifndef DSR_DEFS_SVH
`define DSR_DEFS_SVH

// Word addresses of the read-only status group.
`define DSR_OFF_MODEL     16'h0000
`define DSR_OFF_REVISION  16'h0001
`define DSR_OFF_NODE      16'h0002
`define DSR_OFF_MODE      16'h0003
`define DSR_OFF_ACTIVITY  16'h0004
`define DSR_OFF_DIRECTION 16'h0005
`define DSR_OFF_FAULT     16'h0006
`define DSR_OFF_FLAGS     16'h0007
`define DSR_OFF_INPUTS    16'h0008
`define DSR_OFF_OUTPUTS   16'h0009
`define DSR_OFF_POS_HI    16'h000A
`define DSR_OFF_POS_LO    16'h000B

// Bit positions in the motion flag word.
`define DSR_MF_REACHED    0
`define DSR_MF_HOMED      1
`define DSR_MF_TURNING    2
`define DSR_MF_ALARM      3
`define DSR_MF_RELEASED   4
`define DSR_MF_AT_TARGET  5

// Bit positions in the input and output level words.
`define DSR_IN_PULSE      0
`define DSR_IN_DIRECTION  1
`define DSR_IN_GENERAL0   2
`define DSR_OUT_GENERAL0  0

// Operating mode codes.
`define DSR_MODE_POS_VEL  2'h0
`define DSR_MODE_HOMING   2'h1
`define DSR_MODE_TABLE    2'h2

// Fault code limits and reset value of every status word.
`define DSR_FAULT_NONE    3'h0
`define DSR_FAULT_MAX     3'h5
`define DSR_RST_WORD      16'h0000

`endif

// *** hdl/dsr_pkg.sv ***
`default_nettype none

package dsr_pkg;

    // Reply state of the register read port.
    typedef enum logic {
        DSR_IDLE,
        DSR_REPLY
    } dsr_resp_type;

    typedef logic [15:0] dsr_word_type;

endpackage

`default_nettype wire

// *** hdl/dsr_pos_snapshot.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dsr_defs.svh"

// Keeps the 32-bit position coherent across two separate word reads.
module dsr_pos_snapshot
    import dsr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [31:0] position_actual,
    input  wire logic [31:0] position_command,
    dsr_snap_if.snap         snap
);

    typedef struct packed {
        logic [31:0] pos;
        logic [15:0] lo_hold;
        logic        lo_held;
        logic        at_target;
    } dsr_snap_state_type;

    dsr_snap_state_type s_q;
    dsr_snap_state_type s_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Reading the upper half freezes the lower half, so a master that reads the
    // pair in address order never sees a carry between the two words.
    always_comb begin
        s_d = s_q;
        s_d.pos = position_actual;
        s_d.at_target = (position_actual == position_command);
        if (snap.take_hi) begin
            s_d.lo_hold = s_q.pos[15:0];
            s_d.lo_held = 1'b1;
        end else if (snap.take_lo) begin
            s_d.lo_held = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Upper half at the lower address, lower half at the next one.
    assign snap.pos_hi    = s_q.pos[31:16];
    assign snap.pos_lo    = s_q.lo_held ? s_q.lo_hold : s_q.pos[15:0];
    assign snap.at_target = s_q.at_target;

endmodule

`default_nettype wire

// *** hdl/dsr_snap_if.sv ***
`timescale 1ns/1ps
`default_nettype none

// Carries the position words between the register bank and its snapshot holder.
interface dsr_snap_if;
    logic        take_hi;
    logic        take_lo;
    logic [15:0] pos_hi;
    logic [15:0] pos_lo;
    logic        at_target;

    modport bank (output take_hi, output take_lo, input pos_hi, input pos_lo, input at_target);
    modport snap (input take_hi, input take_lo, output pos_hi, output pos_lo, output at_target);
endinterface

`default_nettype wire

// *** hdl/dsr_status_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dsr_defs.svh"

// Contract
// - Word zero is a fixed read-only model code, upper and lower byte.
// - The node register returns the bus node number in use; read-only.
// - Mode code: 0 position or velocity, 1 homing, 2 position table.
// - Direction reads 0 for counterclockwise (positive), 1 for clockwise (negative).
// - Fault code reads 0 when normal and 1 to 5 on a fault.
// - Flag bit 0 marks position reached, bit 1 homing completed.
// - Flag bit 2 rotating, bit 3 alarm active, bit 4 winding released.
// - Flag bit 5 marks actual equals commanded position; bits 6 to 15 reserved.
// - Input word bit 0 is the pulse input, bit 1 the direction input.
// - Five general inputs sit on bits 2 to 6; bits 7 to 15 reserved.
// - An input bit reads 1 at its active level, 0 otherwise.
// - Three outputs sit on bits 0 to 2; bit 3 undefined, 4 to 15 reserved.
// - An output bit reads 1 while driven active, 0 while inactive.
// - Position is two read-only words, upper half at the lower address.
module dsr_status_regs
    import dsr_pkg::*;
#(
    parameter logic [7:0]  MODEL_UPPER = 8'hA1,   // Arbitrary value.
    parameter logic [7:0]  MODEL_LOWER = 8'h4C,   // Arbitrary value.
    parameter logic [15:0] REVISION    = 16'h0A0B // Arbitrary value.
)
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Request side of the frame handler.
    input  wire logic        rd_req,
    input  wire logic        wr_req,
    input  wire logic [15:0] reg_addr,
    output logic             reg_ack,
    output logic [15:0]      rd_data,
    output logic             reg_error,
    // Live status from the drive.
    input  wire logic [7:0]  node_number,
    input  wire logic [1:0]  op_mode_code,
    input  wire logic        shaft_turning,
    input  wire logic        rotation_cw,
    input  wire logic [2:0]  fault_code_in,
    input  wire logic        pos_reached,
    input  wire logic        homing_done,
    input  wire logic        alarm_active,
    input  wire logic        winding_released,
    input  wire logic [31:0] position_actual,
    input  wire logic [31:0] position_command,
    // Raw terminal levels and the level that counts as active on each.
    input  wire logic        step_pulse_input,
    input  wire logic        direction_input,
    input  wire logic        general_input_0,
    input  wire logic        general_input_1,
    input  wire logic        general_input_2,
    input  wire logic        general_input_3,
    input  wire logic        general_input_4,
    input  wire logic [6:0]  input_active_high,
    input  wire logic        general_output_0,
    input  wire logic        general_output_1,
    input  wire logic        general_output_2,
    input  wire logic [2:0]  output_active_high
);

    ////////////////////////////////////////////////////////////////////////////////
    // State of the bank.

    typedef struct packed {
        dsr_word_type mode;
        dsr_word_type activity;
        dsr_word_type direction;
        dsr_word_type fault;
        dsr_word_type flags;
        dsr_word_type inputs;
        dsr_word_type outputs;
        dsr_word_type node;
        dsr_word_type data;
        logic         error;
        dsr_resp_type resp;
    } dsr_bank_state_type;

    dsr_bank_state_type s_q;
    dsr_bank_state_type s_d;

    logic [6:0] in_raw;
    logic [2:0] out_raw;
    logic [6:0] out_act;
    logic       hit;
    dsr_word_type lookup;

    dsr_snap_if snap_bus ();

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Turns raw terminal levels into active flags; a set polarity bit means active high.
    function automatic logic [6:0] active_levels(input logic [6:0] raw, input logic [6:0] hi);
        active_levels = ~(raw ^ hi);
    endfunction

    // Widens a narrow status code to a register word.
    function automatic dsr_word_type widen(input logic [2:0] v);
        widen = {13'h0000, v};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Position words live in the snapshot holder.

    dsr_pos_snapshot u_snap (
        .clk              (clk),
        .rst_n            (rst_n),
        .position_actual  (position_actual),
        .position_command (position_command),
        .snap             (snap_bus.snap)
    );

    // Only a genuine read of a position word moves the snapshot.
    assign snap_bus.take_hi = rd_req && !wr_req && (reg_addr == `DSR_OFF_POS_HI);
    assign snap_bus.take_lo = rd_req && !wr_req && (reg_addr == `DSR_OFF_POS_LO);

    ////////////////////////////////////////////////////////////////////////////////
    // Terminal levels in documented bit order.

    assign in_raw  = {general_input_4, general_input_3, general_input_2,
                      general_input_1, general_input_0, direction_input,
                      step_pulse_input};
    assign out_raw = {general_output_2, general_output_1, general_output_0};

    // A function result cannot be part-selected, so output polarity goes through a net.
    assign out_act = active_levels({4'h0, out_raw}, {4'h0, output_active_high});

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode of the read-only group; anything else is an illegal address.

    always_comb begin
        hit    = 1'b1;
        lookup = `DSR_RST_WORD;
        case (reg_addr)
            `DSR_OFF_MODEL:     lookup = {MODEL_UPPER, MODEL_LOWER};
            `DSR_OFF_REVISION:  lookup = REVISION;
            `DSR_OFF_NODE:      lookup = s_q.node;
            `DSR_OFF_MODE:      lookup = s_q.mode;
            `DSR_OFF_ACTIVITY:  lookup = s_q.activity;
            `DSR_OFF_DIRECTION: lookup = s_q.direction;
            `DSR_OFF_FAULT:     lookup = s_q.fault;
            `DSR_OFF_FLAGS:     lookup = s_q.flags;
            `DSR_OFF_INPUTS:    lookup = s_q.inputs;
            `DSR_OFF_OUTPUTS:   lookup = s_q.outputs;
            `DSR_OFF_POS_HI:    lookup = snap_bus.pos_hi;
            `DSR_OFF_POS_LO:    lookup = snap_bus.pos_lo;
            default:            hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state: sample live status every cycle, then serve one request.
    // Status words are registered so that a reply never changes under the
    // frame handler while it serialises the word onto the line.

    always_comb begin
        s_d = s_q;

        // Node number is whatever the bus side uses now; it cannot be written.
        s_d.node = {8'h00, node_number};

        // An undefined mode code keeps the last legal one rather than leak out.
        if (op_mode_code == `DSR_MODE_POS_VEL || op_mode_code == `DSR_MODE_HOMING ||
            op_mode_code == `DSR_MODE_TABLE) begin
            s_d.mode = {14'h0000, op_mode_code};
        end

        s_d.activity  = {15'h0000, shaft_turning};
        s_d.direction = {15'h0000, rotation_cw};

        // Fault codes above the documented range are reported as the highest one.
        if (fault_code_in > `DSR_FAULT_MAX) begin
            s_d.fault = widen(`DSR_FAULT_MAX);
        end else begin
            s_d.fault = widen(fault_code_in);
        end

        // Motion flags; reserved bits stay zero.
        s_d.flags = `DSR_RST_WORD;
        s_d.flags[`DSR_MF_REACHED]   = pos_reached;
        s_d.flags[`DSR_MF_HOMED]     = homing_done;
        s_d.flags[`DSR_MF_TURNING]   = shaft_turning;
        s_d.flags[`DSR_MF_ALARM]     = alarm_active;
        s_d.flags[`DSR_MF_RELEASED]  = winding_released;
        s_d.flags[`DSR_MF_AT_TARGET] = snap_bus.at_target;

        // Terminal words; undefined and reserved bits read zero.
        s_d.inputs = {9'h000, active_levels(in_raw, input_active_high)};
        s_d.outputs = {13'h0000, out_act[2:0]};

        // Reply path: one answer per request, the cycle after it is taken.
        case (s_q.resp)
            DSR_IDLE,
            DSR_REPLY: begin
                s_d.resp  = DSR_IDLE;
                s_d.error = 1'b0;
                if (wr_req) begin
                    // Every word here is read-only, so a write is refused.
                    s_d.resp  = DSR_REPLY;
                    s_d.error = 1'b1;
                    s_d.data  = `DSR_RST_WORD;
                end else if (rd_req) begin
                    s_d.resp  = DSR_REPLY;
                    s_d.error = !hit;
                    s_d.data  = hit ? lookup : `DSR_RST_WORD;
                end
            end
            default: begin
                s_d.resp = DSR_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs. The serial framing itself sits in the frame handler outside.

    assign reg_ack   = (s_q.resp == DSR_REPLY);
    assign rd_data   = s_q.data;
    assign reg_error = s_q.error;

endmodule

`default_nettype wire

// *** verif/dsr_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Frame handler stand-in: turns each bus request into one register transfer.
module dsr_master_model (
    input  wire logic        clk,
    output logic             rd_req,
    output logic             wr_req,
    output logic [15:0]      reg_addr,
    input  wire logic        reg_ack,
    input  wire logic [15:0] rd_data,
    input  wire logic        reg_error
);
    // Idle request lines from time zero.
    initial begin
        rd_req = 1'h0;
        wr_req = 1'h0;
        reg_addr = 16'hFFFF;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One request pulse, driven at the falling edge; the answer is taken a cycle later.
    // A released address shows its inverse so a stale value can never pass for a hold.
    task automatic xfer(input logic wr, input logic [15:0] a, output logic [15:0] d,
                        output logic e, output logic k);
        @(negedge clk);
        rd_req = ~wr;
        wr_req = wr;
        reg_addr = a;
        @(negedge clk);
        rd_req = 1'h0;
        wr_req = 1'h0;
        reg_addr = ~a;
        k = reg_ack;
        d = rd_data;
        e = reg_error;
    endtask
endmodule
`default_nettype wire

// *** verif/dsr_status_regs_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// Watches the register port of the status bank from its top-level pins only.
module dsr_status_regs_assertions #(
    parameter logic [7:0] MODEL_UPPER = 8'hA1,
    parameter logic [7:0] MODEL_LOWER = 8'h4C
)(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        rd_req,
    input wire logic        wr_req,
    input wire logic [15:0] reg_addr,
    input wire logic        reg_ack,
    input wire logic [15:0] rd_data,
    input wire logic        reg_error,
    input wire logic [7:0]  node_number,
    input wire logic        shaft_turning,
    input wire logic        rotation_cw
);
    // A write wins over a read on the same edge, so only a bare read counts here.
    wire logic rd_go = rd_req & ~wr_req;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////////
    // Status values are two edges old when the answer is sampled.
    property p_write_refused; wr_req |=> reg_ack && reg_error && rd_data == 16'h0000; endproperty
    a_write_refused: assert property (p_write_refused) else $error("write not refused");
    property p_model; rd_go && reg_addr == 16'h0000 |=> reg_ack && !reg_error
        && rd_data == {MODEL_UPPER, MODEL_LOWER}; endproperty
    a_model: assert property (p_model) else $error("model word wrong");
    property p_node; rd_go && reg_addr == 16'h0002 |=> rd_data == {8'h00, $past(node_number, 2)};
    endproperty
    a_node: assert property (p_node) else $error("node word wrong");
    property p_mode; rd_go && reg_addr == 16'h0003 |=> rd_data <= 16'h0002; endproperty
    a_mode: assert property (p_mode) else $error("mode code out of range");
    property p_activity; rd_go && reg_addr == 16'h0004 |=>
        rd_data == {15'h0000, $past(shaft_turning, 2)}; endproperty
    a_activity: assert property (p_activity) else $error("activity word wrong");
    property p_direction; rd_go && reg_addr == 16'h0005 |=>
        rd_data == {15'h0000, $past(rotation_cw, 2)}; endproperty
    a_direction: assert property (p_direction) else $error("direction word wrong");
    property p_fault; rd_go && reg_addr == 16'h0006 |=> rd_data <= 16'h0005; endproperty
    a_fault: assert property (p_fault) else $error("fault code out of range");
    property p_flags; rd_go && reg_addr == 16'h0007 |=> rd_data[15:6] == 10'h000
        && rd_data[2] == $past(shaft_turning, 2); endproperty
    a_flags: assert property (p_flags) else $error("flag word wrong");
    property p_inputs; rd_go && reg_addr == 16'h0008 |=> rd_data[15:7] == 9'h000; endproperty
    a_inputs: assert property (p_inputs) else $error("input word reserved bits set");
    property p_outputs; rd_go && reg_addr == 16'h0009 |=> rd_data[15:3] == 13'h0000; endproperty
    a_outputs: assert property (p_outputs) else $error("output word reserved bits set");

    // An answer only ever follows a request taken one edge earlier.
    property p_quiet; !rd_req && !wr_req |=> !reg_ack && !reg_error; endproperty
    a_quiet: assert property (p_quiet) else $error("answer without request");

    // Main scenarios: refused write, split position read, clamped fault.
    c_write: cover property (wr_req ##1 reg_error);
    c_pair: cover property (rd_go && reg_addr == 16'h000A ##[1:8] rd_go && reg_addr == 16'h000B);
    c_fault: cover property (rd_go && reg_addr == 16'h0006 ##1 rd_data == 16'h0005);
endmodule
`default_nettype wire

// *** verif/dsr_status_regs_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module dsr_status_regs_test;
    logic        clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        rd_req, wr_req, reg_ack, reg_error, cw = 1'h0;
    logic [15:0] reg_addr, rd_data;
    logic [7:0]  node = 8'h00;
    logic [1:0]  mode = 2'h0;
    logic [2:0]  fault = 3'h0, out_raw = 3'h0, out_ah = 3'h5;
    logic [4:0]  flags = 5'h00;
    logic [31:0] pos_act = 32'h0, pos_cmd = 32'h1;
    logic [6:0]  in_raw = 7'h00, in_ah = 7'h55;
    int          mismatches = 0, compares = 0;

    always #5 clk = ~clk;

    dsr_status_regs dut_u (.clk(clk), .rst_n(rst_n), .rd_req(rd_req), .wr_req(wr_req),
        .reg_addr(reg_addr), .reg_ack(reg_ack), .rd_data(rd_data), .reg_error(reg_error),
        .node_number(node), .op_mode_code(mode), .shaft_turning(flags[2]),
        .rotation_cw(cw), .fault_code_in(fault), .pos_reached(flags[0]),
        .homing_done(flags[1]), .alarm_active(flags[3]), .winding_released(flags[4]),
        .position_actual(pos_act), .position_command(pos_cmd),
        .step_pulse_input(in_raw[0]), .direction_input(in_raw[1]),
        .general_input_0(in_raw[2]), .general_input_1(in_raw[3]),
        .general_input_2(in_raw[4]), .general_input_3(in_raw[5]),
        .general_input_4(in_raw[6]), .input_active_high(in_ah),
        .general_output_0(out_raw[0]), .general_output_1(out_raw[1]),
        .general_output_2(out_raw[2]), .output_active_high(out_ah));

    dsr_master_model m_u (.clk(clk), .rd_req(rd_req), .wr_req(wr_req), .reg_addr(reg_addr),
        .reg_ack(reg_ack), .rd_data(rd_data), .reg_error(reg_error));

    ////////////////////////////////////////////////////////////////////////////////
    // Gives a changed input two edges to reach the status words and the snapshot.
    task automatic settle();
        repeat (2) @(negedge clk);
    endtask

    // One transfer and one comparison of data, error flag and answer strobe.
    task automatic chk(input logic w, input logic [15:0] a, input logic [15:0] exp,
                       input logic ee);
        logic [15:0] d;
        logic        e;
        logic        k;
        m_u.xfer(w, a, d, e, k);
        compares++;
        if (k !== 1'h1 || d !== exp || e !== ee) begin
            mismatches++;
            $display("mismatch reg %h expected %h/%b seen %h/%b ack %b", a, exp, ee, d, e, k);
        end
    endtask

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence; inputs change only at falling edges.
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'h1;
        settle();
        chk(1'h0, 16'h0000, 16'hA14C, 1'h0);
        chk(1'h0, 16'h0001, 16'h0A0B, 1'h0);
        node = 8'h1D;
        settle();
        chk(1'h0, 16'h0002, {8'h00, node}, 1'h0);
        for (int m = 0; m < 4; m++) begin
            mode = m[1:0];
            settle();
            chk(1'h0, 16'h0003, (m == 3) ? 16'h0002 : 16'(m), 1'h0);
        end
        for (int f = 0; f < 8; f++) begin
            fault = f[2:0];
            settle();
            chk(1'h0, 16'h0006, (f > 5) ? 16'h0005 : 16'(f), 1'h0);
        end
        for (int i = 0; i < 6; i++) begin
            flags = 5'(1 << i);
            cw = i[0];
            pos_cmd = (i == 5) ? pos_act : pos_act + 32'h1;
            settle();
            chk(1'h0, 16'h0007, 16'h0001 << i, 1'h0);
            chk(1'h0, 16'h0004, {15'h0000, flags[2]}, 1'h0);
            chk(1'h0, 16'h0005, {15'h0000, cw}, 1'h0);
        end
        // Mixed polarities make both the active-high and active-low paths count.
        for (int i = 0; i < 8; i++) begin
            in_raw = 7'(1 << i);
            out_raw = i[2:0];
            settle();
            chk(1'h0, 16'h0008, {9'h000, (in_raw & in_ah) | ~(in_raw | in_ah)},
                1'h0);
            chk(1'h0, 16'h0009, {13'h0000, (out_raw & out_ah) | ~(out_raw | out_ah)},
                1'h0);
        end
        pos_act = 32'h1234ABCD;
        settle();
        chk(1'h0, 16'h000A, 16'h1234, 1'h0);
        pos_act = 32'h5678EF01;
        settle();
        chk(1'h0, 16'h000B, 16'hABCD, 1'h0);
        chk(1'h0, 16'h000B, 16'hEF01, 1'h0);
        chk(1'h1, 16'h0002, 16'h0000, 1'h1);
        chk(1'h0, 16'h000C, 16'h0000, 1'h1);
        print_verdict();
    end

    // Cuts a hung run short; the sequence needs well under a thousand cycles.
    initial begin
        #100000;
        mismatches++;
        print_verdict();
    end
endmodule

bind dsr_status_regs dsr_status_regs_assertions #(.MODEL_UPPER(MODEL_UPPER),
    .MODEL_LOWER(MODEL_LOWER)) chk_u (.clk(clk), .rst_n(rst_n), .rd_req(rd_req),
    .wr_req(wr_req), .reg_addr(reg_addr), .reg_ack(reg_ack), .rd_data(rd_data),
    .reg_error(reg_error), .node_number(node_number), .shaft_turning(shaft_turning),
    .rotation_cw(rotation_cw));
`default_nettype wire
